// ### design/rcr_pkg.sv
`default_nettype none
package rcr_pkg;
   // register offsets, byte addressed
   localparam logic [7:0] SWITCHER_TOP_CONFIG_OFS    = 8'h2F;
   localparam logic [7:0] LINREG0_VOLTAGE_CONFIG_OFS = 8'h38;
   localparam logic [7:0] LINREG0_CONTROL_CONFIG_OFS = 8'h39;
   localparam logic [7:0] LINREG1_VOLTAGE_CONFIG_OFS = 8'h3A;

   // field positions
   localparam int FLAG_POS    = 7;
   localparam int DRV_LSB     = 0;
   localparam int DRV_W       = 2;
   localparam int TV_LSB      = 0;
   localparam int TV_W        = 7;
   localparam int RSVD_POS    = 7;
   localparam int MODE_POS    = 4;
   localparam int ADE_POS     = 3;
   localparam int EN_LSB      = 0;
   localparam int EN_W        = 3;
   localparam int CTRL_W      = 5;

   // reset values; the factory programmed flag has none here, reset loads it from factory_input_limit_flag_i
   localparam logic [1:0] DRV_RST          = 2'h0;
   localparam logic [7:0] LINREG0_V_RST    = 8'h00;
   localparam logic [4:0] LINREG0_CTRL_RST = 5'h04;
   localparam logic [7:0] LINREG1_V_RST    = 8'h00;

   // enable field codes
   localparam logic [2:0] EN_SLOT_MAX  = 3'h3;
   localparam logic [2:0] EN_OFF_A     = 3'h4;
   localparam logic [2:0] EN_OFF_B     = 3'h5;
   localparam logic [2:0] EN_ON_A      = 3'h6;
   localparam logic [2:0] EN_ON_B      = 3'h7;

   // target voltage transfer, millivolts
   localparam int         MV_W    = 12;
   localparam logic [11:0] MV_BASE = 12'h320;
   localparam logic [11:0] MV_STEP = 12'h019;

   function automatic logic [11:0] code_to_mv(input logic [6:0] code);
      code_to_mv = 12'(MV_BASE + MV_STEP * {5'h00, code});
   endfunction
endpackage
`default_nettype wire

// ### design/rcr_enable_decode.sv
`default_nettype none
// resolves a regulator's enable field against the power sequencer slots
module rcr_enable_decode (
   // configuration
   input  wire logic [2:0] enable_select_i,
   input  wire logic       discharge_enable_i,
   // sequencer
   input  wire logic [3:0] seq_slot_on_i,
   // result
   output logic            reg_on_o,
   output logic            discharge_on_o
);
   always_comb begin
      case (enable_select_i)
         rcr_pkg::EN_OFF_A, rcr_pkg::EN_OFF_B: reg_on_o = 1'b0;
         rcr_pkg::EN_ON_A, rcr_pkg::EN_ON_B:   reg_on_o = 1'b1;
         default:                              reg_on_o = seq_slot_on_i[enable_select_i[1:0]];
      endcase
      discharge_on_o = discharge_enable_i & ~reg_on_o;
   end
endmodule
`default_nettype wire

// ### design/rcr_config_regs.sv
`default_nettype none
module rcr_config_regs (
   // clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        rst_i,
   // byte register port behind the serial interface
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   input  wire logic [7:0]  reg_addr_i,
   input  wire logic [7:0]  reg_wdata_i,
   output logic [7:0]       reg_rdata_o,
   output logic             reg_ack_o,
   // factory settings and sequencer
   input  wire logic        factory_input_limit_flag_i,
   input  wire logic [3:0]  seq_slot_on_i,
   // configuration outputs
   output logic             input_limit_interpretation_flag_o,
   output logic [1:0]       switcher_drive_strength_o,
   output logic [6:0]       linreg0_target_voltage_o,
   output logic [11:0]      linreg0_target_mv_o,
   output logic             linreg0_load_switch_mode_o,
   output logic             linreg0_on_o,
   output logic             linreg0_discharge_on_o,
   output logic [6:0]       linreg1_target_voltage_o,
   output logic [11:0]      linreg1_target_mv_o
);
   typedef struct packed {
      logic        flag;
      logic [1:0]  drv;
      logic [7:0]  lr0_v;
      logic [4:0]  lr0_c;
      logic [7:0]  lr1_v;
      logic [7:0]  rdata;
      logic        ack;
      logic        lr0_on;
      logic        lr0_dis;
      logic [11:0] lr0_mv;
      logic [11:0] lr1_mv;
   } rcr_state_t;

   rcr_state_t q;
   rcr_state_t next_q;
   logic       dec_on;
   logic       dec_dis;

   rcr_enable_decode u_lr0_dec (
      .enable_select_i    (q.lr0_c[rcr_pkg::EN_LSB +: rcr_pkg::EN_W]),
      .discharge_enable_i (q.lr0_c[rcr_pkg::ADE_POS]),
      .seq_slot_on_i      (seq_slot_on_i),
      .reg_on_o           (dec_on),
      .discharge_on_o     (dec_dis)
   );

   always_comb begin
      next_q = q;
      next_q.ack = 1'b0;
      if (rst_i) begin
         next_q.flag   = factory_input_limit_flag_i;
         next_q.drv    = rcr_pkg::DRV_RST;
         next_q.lr0_v  = rcr_pkg::LINREG0_V_RST;
         next_q.lr0_c  = rcr_pkg::LINREG0_CTRL_RST;
         next_q.lr1_v  = rcr_pkg::LINREG1_V_RST;
         next_q.rdata  = 8'h00;
         next_q.lr0_on = 1'b0;
         next_q.lr0_dis = 1'b0;
         next_q.lr0_mv = rcr_pkg::MV_BASE;
         next_q.lr1_mv = rcr_pkg::MV_BASE;
      end else begin
         if (reg_wr_i) begin
            next_q.ack = 1'b1;
            case (reg_addr_i)
               rcr_pkg::SWITCHER_TOP_CONFIG_OFS:
                  next_q.drv = reg_wdata_i[rcr_pkg::DRV_LSB +: rcr_pkg::DRV_W];
               rcr_pkg::LINREG0_VOLTAGE_CONFIG_OFS:
                  next_q.lr0_v = reg_wdata_i;
               rcr_pkg::LINREG0_CONTROL_CONFIG_OFS:
                  next_q.lr0_c = reg_wdata_i[rcr_pkg::CTRL_W-1:0];
               rcr_pkg::LINREG1_VOLTAGE_CONFIG_OFS:
                  next_q.lr1_v = reg_wdata_i;
               default: ;
            endcase
         end else if (reg_rd_i) begin
            next_q.ack = 1'b1;
            case (reg_addr_i)
               rcr_pkg::SWITCHER_TOP_CONFIG_OFS:   next_q.rdata = {q.flag, 5'h00, q.drv};
               rcr_pkg::LINREG0_VOLTAGE_CONFIG_OFS: next_q.rdata = q.lr0_v;
               rcr_pkg::LINREG0_CONTROL_CONFIG_OFS: next_q.rdata = {3'h0, q.lr0_c};
               rcr_pkg::LINREG1_VOLTAGE_CONFIG_OFS: next_q.rdata = q.lr1_v;
               default:                            next_q.rdata = 8'h00;
            endcase
         end
         next_q.lr0_on  = dec_on;
         next_q.lr0_dis = dec_dis;
         next_q.lr0_mv  = rcr_pkg::code_to_mv(q.lr0_v[rcr_pkg::TV_LSB +: rcr_pkg::TV_W]);
         next_q.lr1_mv  = rcr_pkg::code_to_mv(q.lr1_v[rcr_pkg::TV_LSB +: rcr_pkg::TV_W]);
      end
   end

   always_ff @(posedge sys_clk_i) begin
      q <= next_q;
   end

   assign reg_rdata_o                       = q.rdata;
   assign reg_ack_o                         = q.ack;
   assign input_limit_interpretation_flag_o = q.flag;
   assign switcher_drive_strength_o         = q.drv;
   assign linreg0_target_voltage_o          = q.lr0_v[rcr_pkg::TV_LSB +: rcr_pkg::TV_W];
   assign linreg0_target_mv_o               = q.lr0_mv;
   assign linreg0_load_switch_mode_o        = q.lr0_c[rcr_pkg::MODE_POS];
   assign linreg0_on_o                      = q.lr0_on;
   assign linreg0_discharge_on_o            = q.lr0_dis;
   assign linreg1_target_voltage_o          = q.lr1_v[rcr_pkg::TV_LSB +: rcr_pkg::TV_W];
   assign linreg1_target_mv_o               = q.lr1_mv;

   // checks
   property p_flag_fixed;
      @(posedge sys_clk_i) disable iff (rst_i)
      !$past(rst_i) |-> $stable(input_limit_interpretation_flag_o);
   endproperty
   a_flag_fixed: assert property (p_flag_fixed) else $error("factory flag changed");

   property p_drive_write;
      @(posedge sys_clk_i) disable iff (rst_i)
      reg_wr_i && reg_addr_i == rcr_pkg::SWITCHER_TOP_CONFIG_OFS
      |=> switcher_drive_strength_o == $past(reg_wdata_i[1:0]) && reg_ack_o;
   endproperty
   a_drive_write: assert property (p_drive_write) else $error("drive strength not written");

   property p_mv_map;
      @(posedge sys_clk_i) disable iff (rst_i)
      !$past(rst_i) |-> linreg0_target_mv_o == 12'(12'h320 + 12'h019 * {5'h00, $past(linreg0_target_voltage_o)});
   endproperty
   a_mv_map: assert property (p_mv_map) else $error("linreg0 millivolt decode wrong");

   property p_mode_write;
      @(posedge sys_clk_i) disable iff (rst_i)
      reg_wr_i && reg_addr_i == rcr_pkg::LINREG0_CONTROL_CONFIG_OFS
      |=> linreg0_load_switch_mode_o == $past(reg_wdata_i[4]);
   endproperty
   a_mode_write: assert property (p_mode_write) else $error("operation select not written");

   property p_discharge;
      @(posedge sys_clk_i) disable iff (rst_i)
      !$past(rst_i) |-> linreg0_discharge_on_o == ($past(q.lr0_c[3]) && !linreg0_on_o);
   endproperty
   a_discharge: assert property (p_discharge) else $error("discharge path wrong");

   property p_slot;
      @(posedge sys_clk_i) disable iff (rst_i)
      !$past(rst_i) && $past(q.lr0_c[2]) == 1'b0
      |-> linreg0_on_o == $past(seq_slot_on_i[q.lr0_c[1:0]]);
   endproperty
   a_slot: assert property (p_slot) else $error("sequencer slot not followed");

   property p_forced;
      @(posedge sys_clk_i) disable iff (rst_i)
      !$past(rst_i) && $past(q.lr0_c[2]) |-> linreg0_on_o == $past(q.lr0_c[1]);
   endproperty
   a_forced: assert property (p_forced) else $error("forced enable not obeyed");

   property p_read_back;
      @(posedge sys_clk_i) disable iff (rst_i)
      reg_wr_i && reg_addr_i == rcr_pkg::LINREG1_VOLTAGE_CONFIG_OFS ##1
      !reg_wr_i && reg_rd_i && reg_addr_i == rcr_pkg::LINREG1_VOLTAGE_CONFIG_OFS
      |=> reg_ack_o && reg_rdata_o == $past(reg_wdata_i, 2);
   endproperty
   a_read_back: assert property (p_read_back) else $error("read back mismatch");

   property p_ack_timing;
      @(posedge sys_clk_i) disable iff (rst_i)
      (reg_wr_i || reg_rd_i) |=> reg_ack_o ##1 (reg_ack_o == $past(reg_wr_i || reg_rd_i));
   endproperty
   a_ack_timing: assert property (p_ack_timing) else $error("ack timing wrong");

   property p_unmapped_read;
      @(posedge sys_clk_i) disable iff (rst_i)
      reg_rd_i && !reg_wr_i && reg_addr_i != rcr_pkg::SWITCHER_TOP_CONFIG_OFS
      && reg_addr_i != rcr_pkg::LINREG0_VOLTAGE_CONFIG_OFS && reg_addr_i != rcr_pkg::LINREG0_CONTROL_CONFIG_OFS
      && reg_addr_i != rcr_pkg::LINREG1_VOLTAGE_CONFIG_OFS
      |=> reg_ack_o && reg_rdata_o == 8'h00;
   endproperty
   a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

   property p_top_read;
      @(posedge sys_clk_i) disable iff (rst_i)
      reg_rd_i && !reg_wr_i && reg_addr_i == rcr_pkg::SWITCHER_TOP_CONFIG_OFS
      |=> reg_rdata_o == {input_limit_interpretation_flag_o, 5'h00, switcher_drive_strength_o};
   endproperty
   a_top_read: assert property (p_top_read) else $error("top config read wrong");

   property p_tv_write;
      @(posedge sys_clk_i) disable iff (rst_i)
      reg_wr_i && reg_addr_i == rcr_pkg::LINREG0_VOLTAGE_CONFIG_OFS
      |=> linreg0_target_voltage_o == $past(reg_wdata_i[6:0]);
   endproperty
   a_tv_write: assert property (p_tv_write) else $error("target code not written");

   // no disable here: checks what each reset edge leaves behind
   property p_reset_values;
      @(posedge sys_clk_i)
      rst_i |=> !linreg0_on_o && !linreg0_discharge_on_o && !reg_ack_o
      && switcher_drive_strength_o == rcr_pkg::DRV_RST && linreg0_target_mv_o == rcr_pkg::MV_BASE;
   endproperty
   a_reset_values: assert property (p_reset_values) else $error("reset values wrong");

   property p_flag_capture;
      @(posedge sys_clk_i)
      rst_i |=> input_limit_interpretation_flag_o == $past(factory_input_limit_flag_i);
   endproperty
   a_flag_capture: assert property (p_flag_capture) else $error("factory flag not captured");

   c_forced_on: cover property (@(posedge sys_clk_i) disable iff (rst_i) linreg0_on_o && q.lr0_c[2]);
   c_discharge: cover property (@(posedge sys_clk_i) disable iff (rst_i) linreg0_discharge_on_o);
   c_top_mv:    cover property (@(posedge sys_clk_i) disable iff (rst_i) linreg1_target_mv_o == 12'hF87);
   c_unmapped:  cover property (@(posedge sys_clk_i) disable iff (rst_i) reg_rd_i && reg_addr_i == 8'h00);
   c_lsw_on:    cover property (@(posedge sys_clk_i) disable iff (rst_i) linreg0_load_switch_mode_o && linreg0_on_o);
endmodule
`default_nettype wire

// ### verif/rcr_host_model.sv
`default_nettype none
// host side of the byte register port, one pulse per request
module rcr_host_model (
   // clock
   input  wire logic       clk_i,
   // register port
   output logic            wr_o,
   output logic            rd_o,
   output logic [7:0]      addr_o,
   output logic [7:0]      wdata_o,
   input  wire logic [7:0] rdata_i,
   input  wire logic       ack_i
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      wr_o = 1'b0;
      rd_o = 1'b0;
      addr_o = 8'h00;
      wdata_o = 8'h00;
   end
   task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
                         output logic [7:0] q, output logic ok);
      int n;
      @(posedge clk_i);
      #1;
      wr_o = w;
      rd_o = ~w;
      addr_o = a; // byte access by offset
      wdata_o = (a == 8'h38 || a == 8'h3A) ? (d & 8'h7F) : d; // reserved bit sent as 0
      @(posedge clk_i);
      #1;
      wr_o = 1'b0;
      rd_o = 1'b0;
      addr_o = ~a;
      wdata_o = ~wdata_o;
      n = 0;
      // ack and read data are taken at the edge that samples them
      @(posedge clk_i);
      while (ack_i !== 1'b1 && n < 4) begin
         @(posedge clk_i);
         n++;
      end
      ok = (ack_i === 1'b1) && (n == 0);
      q = rdata_i;
      @(posedge clk_i);
      ok = ok && (ack_i === 1'b0);
      #1;
   endtask
   // write then read of the same offset in back-to-back cycles
   task automatic write_read(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q, output logic ok);
      @(posedge clk_i);
      #1;
      wr_o = 1'b1;
      rd_o = 1'b0;
      addr_o = a;
      wdata_o = (a == 8'h38 || a == 8'h3A) ? (d & 8'h7F) : d; // reserved bit sent as 0
      @(posedge clk_i);
      #1;
      wr_o = 1'b0;
      rd_o = 1'b1; // read follows in the next cycle
      @(posedge clk_i);
      ok = (ack_i === 1'b1);
      #1;
      rd_o = 1'b0;
      addr_o = ~a;
      wdata_o = ~wdata_o;
      @(posedge clk_i);
      ok = ok && (ack_i === 1'b1);
      q = rdata_i;
      @(posedge clk_i);
      ok = ok && (ack_i === 1'b0);
      #1;
   endtask
endmodule
`default_nettype wire

// ### verif/rcr_config_regs_tb.sv
`default_nettype none
module rcr_config_regs_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        wr, rd, ack, fin, flag, load_switch_mode, on, dis, ok, e_on;
   logic [7:0]  addr, wd, rdata, q;
   logic [3:0]  seq;
   logic [1:0]  drv;
   logic [6:0]  tv0, tv1, v;
   logic [11:0] mv0, mv1;
   logic [6:0]  codes [3] = '{7'h00, 7'h01, 7'h7F};
   int          n_fail = 0;
   int          checked = 0;

   always #2.5 clk = ~clk;

   rcr_config_regs dut (
      .sys_clk_i(clk), .rst_i(rst), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
      .reg_wdata_i(wd), .reg_rdata_o(rdata), .reg_ack_o(ack),
      .factory_input_limit_flag_i(fin), .seq_slot_on_i(seq),
      .input_limit_interpretation_flag_o(flag), .switcher_drive_strength_o(drv),
      .linreg0_target_voltage_o(tv0), .linreg0_target_mv_o(mv0), .linreg0_load_switch_mode_o(load_switch_mode),
      .linreg0_on_o(on), .linreg0_discharge_on_o(dis), .linreg1_target_voltage_o(tv1),
      .linreg1_target_mv_o(mv1)
   );
   rcr_host_model host (
      .clk_i(clk), .wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wd), .rdata_i(rdata), .ack_i(ack)
   );

   task automatic print_verdict();
      $display("checks %0d failures %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // one access; a missing or late ack ends the run
   task automatic op(input logic w, input logic [7:0] a, input logic [7:0] d);
      host.access(w, a, d, q, ok);
      if (ok !== 1'b1) begin
         chk(12'h000, 12'h001);
         print_verdict();
      end
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      op(1'b0, a, 8'h00);
      chk(12'(q), 12'(e));
   endtask

   initial begin
      seq = 4'h5;
      fin = 1'b1;
      repeat (10) @(posedge clk);
      #1;
      rst = 1'b0;
      fin = 1'b0;
      chk({10'h000, on, dis}, 12'h000);
      chk(mv0, 12'h320);
      rd_chk(8'h2F, 8'h80);
      rd_chk(8'h39, 8'h04);
      rd_chk(8'h00, 8'h00);
      $display("done reset");
      for (int c = 0; c < 4; c++) begin
         op(1'b1, 8'h2F, 8'h7C | 8'(c));
         rd_chk(8'h2F, 8'h80 | 8'(c));
         chk({10'h000, drv}, 12'(c));
      end
      chk({11'h000, flag}, 12'h001);
      $display("done top");
      foreach (codes[i]) begin
         v = ~codes[i];
         op(1'b1, 8'h38, {1'b0, codes[i]});
         op(1'b1, 8'h3A, {1'b0, v});
         chk(mv0, 12'h320 + 12'h019 * {5'h00, codes[i]});
         chk(mv1, 12'h320 + 12'h019 * {5'h00, v});
         chk({5'h00, tv0}, {5'h00, codes[i]});
         chk({5'h00, tv1}, {5'h00, v});
         rd_chk(8'h3A, {1'b0, v});
      end
      $display("done voltage");
      for (int c = 0; c < 16; c++) begin
         e_on = c[2] ? c[1] : seq[c[1:0]];
         op(1'b1, 8'h39, {3'b111, c[0], c[3], c[2:0]});
         chk({11'h000, on}, {11'h000, e_on});
         chk({11'h000, dis}, {11'h000, c[3] & ~e_on});
         chk({11'h000, load_switch_mode}, 12'(c[0]));
         rd_chk(8'h39, {3'b000, c[0], c[3], c[2:0]});
      end
      op(1'b1, 8'h39, 8'h0A);
      chk({10'h000, on, dis}, 12'h002);
      seq = 4'h1;
      repeat (2) @(posedge clk);
      #1;
      chk({10'h000, on, dis}, 12'h001);
      $display("done control");
      host.write_read(8'h3A, 8'h2A, q, ok);
      chk({11'h000, ok}, 12'h001);
      chk(12'(q), 12'h02A);
      $display("done back to back");
      rst = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      rst = 1'b0;
      chk({10'h000, on, dis}, 12'h000);
      chk({11'h000, flag}, 12'h000);
      chk({10'h000, drv}, 12'h000);
      rd_chk(8'h39, 8'h04);
      $display("done reset again");
      print_verdict();
   end
endmodule
`default_nettype wire
